// ===== logic/rtc_counter.sv
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_counter (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // reference clock sources
  input wire logic xtal_clk_in,
  input wire logic ext_clk_in,
  input wire logic osc_clk_in,
  // register bus
  input wire rtc_pkg::bus_req_s bus_in,
  output rtc_pkg::bus_resp_s bus_out,
  // interrupt and events
  output logic irq_out,
  output logic ovf_event_out,
  output logic cmp_event_out,
  output logic [7:0] pit_level_out
);
  import rtc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic cnt_en;
  logic corr_en;
  logic [3:0] psc_sel;
  clk_src_e src_sel;
  logic pit_en;
  logic [3:0] pit_sel;
  logic [2:0] status;
  logic [2:0] inten;
  logic [15:0] count;
  logic [15:0] period;
  logic [15:0] compare;
  logic [7:0] calib;
  logic [14:0] psc;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic osc_last;
  logic [4:0] osc_div;
  logic ref_last;
  logic corr_run;
  logic [19:0] corr_cycles;
  logic [19:0] corr_acc;
  bus_state_e bus_state;

  function automatic logic [14:0] low_mask(input logic [3:0] sel);
    low_mask = (15'h0001 << sel) - 15'h0001;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reference clock path

  // raw clock levels are only ever read by the first stage
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else if (ce_in) begin
      sync_a <= {osc_clk_in, ext_clk_in, xtal_clk_in};
      sync_b <= sync_a;
    end
  end

  wire osc_rise = sync_b[2] && !osc_last;
  wire div32_level = osc_div[4];
  wire ref_level = (src_sel == SRC_XTAL) ? sync_b[0] :
                   (src_sel == SRC_EXT) ? sync_b[1] :
                   (src_sel == SRC_OSC) ? sync_b[2] : div32_level;
  // edge detection needs at least two samples per half period
  wire ref_edge = ref_level && !ref_last;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      osc_last <= 1'b0;
      osc_div <= 5'h00;
      ref_last <= 1'b0;
    end else if (ce_in) begin
      osc_last <= sync_b[2];
      ref_last <= ref_level;
      if (osc_rise) begin
        osc_div <= osc_div + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // crystal correction

  wire xtal_sel = (src_sel == SRC_XTAL);
  wire psc_run = cnt_en || pit_en;
  wire [6:0] corr_ppm = calib[6:0];
  wire [19:0] acc_sum = corr_acc + {13'h0000, corr_ppm};
  wire acc_hit = acc_sum >= `CORR_INTERVAL;
  wire interval_end = corr_cycles == (`CORR_INTERVAL - 20'd1);
  wire corr_fire = corr_run && ref_edge && psc_run && acc_hit;
  // sign set marks a slow crystal
  wire corr_skip = corr_fire && calib[`CALIB_SIGN];
  wire corr_hold = corr_fire && !calib[`CALIB_SIGN];

  // an interval, once started, always runs to its end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      corr_run <= 1'b0;
      corr_cycles <= 20'h00000;
      corr_acc <= 20'h00000;
    end else if (ce_in && ref_edge && psc_run) begin
      if (!corr_run || interval_end) begin
        corr_run <= corr_en && xtal_sel;
        corr_cycles <= 20'h00000;
        corr_acc <= 20'h00000;
      end else begin
        corr_cycles <= corr_cycles + 20'h00001;
        corr_acc <= acc_hit ? acc_sum - `CORR_INTERVAL : acc_sum;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler, counter, tick timer

  wire advance = ref_edge && psc_run;
  wire [14:0] mask = low_mask(psc_sel);
  // hold slows a fast crystal, skip speeds up a slow one
  wire [14:0] next_psc = corr_hold ? psc :
                         corr_skip ? psc + 15'h0002 : psc + 15'h0001;
  wire wrapped = (next_psc & mask) < (psc & mask);
  wire cnt_tick = advance && cnt_en && (mask == 15'h0000 || wrapped) && !corr_hold;
  wire at_period = count == period;
  wire at_compare = count == compare;
  wire ovf_tick = cnt_tick && at_period;
  wire cmp_tick = cnt_tick && at_compare;
  wire [15:0] next_count = at_period ? 16'h0000 : count + 16'h0001;
  wire pit_bit_old = psc[pit_sel];
  wire pit_bit_new = next_psc[pit_sel];
  wire pit_hit = advance && pit_en && pit_sel != 4'h0 && pit_sel != 4'hf &&
                 !pit_bit_old && pit_bit_new;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      psc <= 15'h0000;
      count <= 16'h0000;
    end else if (ce_in) begin
      if (advance) begin
        psc <= next_psc;
      end
      if (cnt_tick) begin
        count <= next_count;
      end
    end
  end

  // overflow and compare events stand until the next reference edge
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ovf_event_out <= 1'b0;
      cmp_event_out <= 1'b0;
      pit_level_out <= 8'h00;
    end else if (ce_in) begin
      if (ref_edge) begin
        ovf_event_out <= ovf_tick;
        cmp_event_out <= cmp_tick;
      end
      pit_level_out <= pit_en ? psc[`LEVEL_TAP_LSB +: 8] : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  wire bus_req = bus_in.read || bus_in.write;
  wire take = bus_req && bus_state == BUS_ACK;
  wire wr = take && bus_in.write;
  wire [5:0] addr = bus_in.address;
  wire [31:0] wd = bus_in.writedata;
  wire [2:0] events = {pit_hit, cmp_tick, ovf_tick};
  wire [2:0] clr = (wr && addr == `ADDR_INTCLR) ? wd[2:0] : 3'h0;
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h00000000;
    if (addr == `ADDR_CTRL) begin
      rd_mux = {24'h000000, src_sel, psc_sel, corr_en, cnt_en};
    end else if (addr == `ADDR_PITCTRL) begin
      rd_mux = {27'h0000000, pit_sel, pit_en};
    end else if (addr == `ADDR_STATUS) begin
      rd_mux = {29'h00000000, status};
    end else if (addr == `ADDR_INTEN) begin
      rd_mux = {29'h00000000, inten};
    end else if (addr == `ADDR_COUNT) begin
      rd_mux = {16'h0000, count};
    end else if (addr == `ADDR_PERIOD) begin
      rd_mux = {16'h0000, period};
    end else if (addr == `ADDR_COMPARE) begin
      rd_mux = {16'h0000, compare};
    end else if (addr == `ADDR_CALIB) begin
      rd_mux = {24'h000000, calib};
    end
  end

  // every access waits exactly one cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      bus_state <= BUS_WAIT;
      bus_out <= '{waitrequest: 1'b1, readdata: 32'h00000000};
    end else if (ce_in) begin
      case (bus_state)
        BUS_WAIT: begin
          if (bus_req) begin
            bus_state <= BUS_ACK;
            bus_out <= '{waitrequest: 1'b0, readdata: rd_mux};
          end
        end
        BUS_ACK: begin
          bus_state <= BUS_WAIT;
          bus_out <= '{waitrequest: 1'b1, readdata: 32'h00000000};
        end
        default: begin
          bus_state <= BUS_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cnt_en <= 1'b0;
      corr_en <= 1'b0;
      psc_sel <= 4'h0;
      src_sel <= SRC_XTAL;
      pit_en <= 1'b0;
      pit_sel <= 4'h0;
      inten <= 3'h0;
      period <= `RST_PERIOD;
      compare <= `RST_COMPARE;
      calib <= 8'h00;
    end else if (ce_in && wr) begin
      if (addr == `ADDR_CTRL) begin
        cnt_en <= wd[`CTRL_CNT_EN];
        corr_en <= wd[`CTRL_CORR_EN];
        psc_sel <= wd[`CTRL_PSC_LSB +: 4];
        src_sel <= clk_src_e'(wd[`CTRL_SRC_LSB +: 2]);
      end else if (addr == `ADDR_PITCTRL) begin
        pit_en <= wd[`PIT_EN];
        pit_sel <= wd[`PIT_SEL_LSB +: 4];
      end else if (addr == `ADDR_INTEN) begin
        inten <= wd[2:0];
      end else if (addr == `ADDR_PERIOD) begin
        period <= wd[15:0];
      end else if (addr == `ADDR_COMPARE) begin
        compare <= wd[15:0];
      end else if (addr == `ADDR_CALIB) begin
        calib <= wd[7:0];
      end
    end
  end

  // a new event beats a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      status <= 3'h0;
      irq_out <= 1'b0;
    end else if (ce_in) begin
      status <= (status & ~clr) | events;
      irq_out <= |(status & inten);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  cnt_step_a: assert property (@(posedge clk_in) disable iff (reset_in)
    ce_in && cnt_tick && !at_period |=> count == $past(count) + 16'h0001)
    else $error("counter did not step");
  cmp_flag_a: assert property (@(posedge clk_in) disable iff (reset_in)
    ce_in && cnt_tick && at_compare |=> status[`ST_CMP] && cmp_event_out)
    else $error("compare match not flagged");
  ovf_flag_a: assert property (@(posedge clk_in) disable iff (reset_in)
    ce_in && cnt_tick && at_period |=> status[`ST_OVF] && ovf_event_out)
    else $error("overflow not flagged");
  cnt_wrap_a: assert property (@(posedge clk_in) disable iff (reset_in)
    ce_in && cnt_tick && at_period |=> count == 16'h0000)
    else $error("counter did not wrap");
  psc_stop_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !cnt_en && !pit_en |=> $stable(psc))
    else $error("prescaler ran while disabled");
  corr_src_a: assert property (@(posedge clk_in) disable iff (reset_in)
    corr_fire |-> corr_run && !$past(corr_run) == 1'b0)
    else $error("correction outside an interval");
  pit_int_a: assert property (@(posedge clk_in) disable iff (reset_in)
    ce_in && pit_hit |=> status[`ST_PIT])
    else $error("tick timer flag missing");
  event_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
    ovf_event_out && !(ce_in && ref_edge) |=> ovf_event_out)
    else $error("overflow event ended early");
  level_tap_a: assert property (@(posedge clk_in) disable iff (reset_in)
    ce_in && pit_en |=> pit_level_out == $past(psc[12:5]))
    else $error("level event tap wrong");
  irq_level_a: assert property (@(posedge clk_in) disable iff (reset_in)
    ce_in |=> irq_out == |($past(status) & $past(inten)))
    else $error("interrupt level wrong");

  ovf_seen_c: cover property (@(posedge clk_in) disable iff (reset_in) ovf_tick && ce_in);
  cmp_seen_c: cover property (@(posedge clk_in) disable iff (reset_in) cmp_tick && ce_in);
  pit_seen_c: cover property (@(posedge clk_in) disable iff (reset_in) pit_hit && ce_in);
  corr_seen_c: cover property (@(posedge clk_in) disable iff (reset_in) corr_skip && ce_in);
endmodule

// ===== logic/rtc_cfg.svh
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// register byte addresses
`define ADDR_CTRL 6'h00
`define ADDR_PITCTRL 6'h04
`define ADDR_STATUS 6'h08
`define ADDR_INTEN 6'h0c
`define ADDR_INTCLR 6'h10
`define ADDR_COUNT 6'h14
`define ADDR_PERIOD 6'h18
`define ADDR_COMPARE 6'h1c
`define ADDR_CALIB 6'h20

// control fields
`define CTRL_CNT_EN 0
`define CTRL_CORR_EN 1
`define CTRL_PSC_LSB 2
`define CTRL_SRC_LSB 6
`define PIT_EN 0
`define PIT_SEL_LSB 1
`define CALIB_SIGN 7

// status bits
`define ST_OVF 0
`define ST_CMP 1
`define ST_PIT 2

// reset values
`define RST_PERIOD 16'hffff
`define RST_COMPARE 16'h0000

// correction interval in reference cycles
`define CORR_INTERVAL 20'd1000000
// first level event tap (divide by 64)
`define LEVEL_TAP_LSB 5

`endif

// ===== logic/rtc_pkg.sv
package rtc_pkg;

  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
  } bus_req_s;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } bus_resp_s;

  typedef enum logic [1:0] {
    BUS_WAIT = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_e;

  typedef enum logic [1:0] {
    SRC_XTAL = 2'h0,
    SRC_EXT = 2'h1,
    SRC_OSC = 2'h2,
    SRC_OSC_DIV32 = 2'h3
  } clk_src_e;

endpackage

// ===== tb/testbench.sv
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module testbench;
  import rtc_pkg::*;
  logic clk_in;
  logic reset_in;
  logic ce_in;
  logic xtal_clk_in;
  logic ext_clk_in;
  logic osc_clk_in;
  bus_req_s req;
  bus_resp_s resp;
  logic irq_out;
  logic ovf_event_out;
  logic cmp_event_out;
  logic [7:0] pit_level_out;
  int err_count;
  int n_tests;

  rtc_counter u_dut (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .xtal_clk_in(xtal_clk_in),
    .ext_clk_in(ext_clk_in),
    .osc_clk_in(osc_clk_in),
    .bus_in(req),
    .bus_out(resp),
    .irq_out(irq_out),
    .ovf_event_out(ovf_event_out),
    .cmp_event_out(cmp_event_out),
    .pit_level_out(pit_level_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // request held until waitrequest low is seen; sampled on the falling edge to avoid races
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    req <= {!wr, wr, a, d};
    do begin
      @(negedge clk_in);
      n++;
    end while (resp.waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_count++;
      $display("unexpected bus hang at %h", a);
    end
    q = resp.readdata;
    @(posedge clk_in);
    req <= '0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    check($sformatf("reg %h", a), q, e);
  endtask

  // n reference rising edges on one pin, 8 peripheral_clock period keeps it under clk/4
  task automatic pulses(input int src, input int n);
    repeat (n) for (int l = 1; l >= 0; l--) begin
      @(posedge clk_in);
      case (src)
        0: xtal_clk_in <= l[0];
        1: ext_clk_in <= l[0];
        default: osc_clk_in <= l[0];
      endcase
      repeat (3) @(posedge clk_in);
    end
    repeat (6) @(posedge clk_in);
  endtask

  task automatic do_reset();
    @(posedge clk_in);
    reset_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    do_reset();
    rc(`ADDR_CTRL, 32'h0);
    rc(`ADDR_PERIOD, 32'h0000ffff);
    rc(`ADDR_COMPARE, 32'h0);
    rc(`ADDR_STATUS, 32'h0);
    rc(`ADDR_COUNT, 32'h0);
    rc(6'h3c, 32'h0);
    wr(`ADDR_COUNT, 32'h5);
    wr(`ADDR_STATUS, 32'h7);
    rc(`ADDR_COUNT, 32'h0);
    rc(`ADDR_STATUS, 32'h0);
    wr(`ADDR_CALIB, 32'h85);
    rc(`ADDR_CALIB, 32'h85);
    rc(`ADDR_INTCLR, 32'h0);
  endtask

  task automatic t_sources();
    for (int s = 0; s < 4; s++) begin
      do_reset();
      wr(`ADDR_CTRL, (s << 6) | 1);
      pulses(s, (s == 3) ? 64 : 5);
      rc(`ADDR_COUNT, (s == 3) ? 32'h2 : 32'h5);
    end
  endtask

  task automatic t_prescale();
    do_reset();
    wr(`ADDR_CTRL, 32'h9);
    pulses(0, 8);
    rc(`ADDR_COUNT, 32'h2);
    pulses(1, 4);
    rc(`ADDR_COUNT, 32'h2);
    // stopped prescaler must not advance, so two more edges fall short of a tick
    wr(`ADDR_CTRL, 32'h0);
    pulses(0, 2);
    wr(`ADDR_CTRL, 32'h9);
    pulses(0, 2);
    rc(`ADDR_COUNT, 32'h2);
  endtask

  task automatic t_match();
    do_reset();
    wr(`ADDR_PERIOD, 32'h3);
    wr(`ADDR_COMPARE, 32'h1);
    wr(`ADDR_INTEN, 32'h3);
    wr(`ADDR_CTRL, 32'h1);
    pulses(0, 1);
    rc(`ADDR_STATUS, 32'h0);
    pulses(0, 1);
    rc(`ADDR_STATUS, 32'h2);
    check("cmp event", cmp_event_out, 1'b1);
    check("irq", irq_out, 1'b1);
    pulses(0, 1);
    check("cmp event", cmp_event_out, 1'b0);
    pulses(0, 1);
    rc(`ADDR_COUNT, 32'h0);
    rc(`ADDR_STATUS, 32'h3);
    check("ovf event", ovf_event_out, 1'b1);
    wr(`ADDR_INTCLR, 32'h3);
    rc(`ADDR_STATUS, 32'h0);
    check("irq", irq_out, 1'b0);
    wr(`ADDR_INTEN, 32'h0);
    pulses(0, 4);
    rc(`ADDR_STATUS, 32'h3);
    check("irq", irq_out, 1'b0);
  endtask

  task automatic t_tick();
    do_reset();
    wr(`ADDR_INTEN, 32'h4);
    wr(`ADDR_PITCTRL, 32'h3);
    pulses(0, 1);
    rc(`ADDR_STATUS, 32'h0);
    pulses(0, 1);
    rc(`ADDR_STATUS, 32'h4);
    check("irq", irq_out, 1'b1);
    rc(`ADDR_COUNT, 32'h0);
    pulses(0, 30);
    check("level", pit_level_out, 8'h01);
    pulses(0, 32);
    check("level", pit_level_out, 8'h02);
    wr(`ADDR_INTCLR, 32'h4);
    wr(`ADDR_PITCTRL, 32'h5);
    pulses(0, 3);
    rc(`ADDR_STATUS, 32'h0);
    pulses(0, 1);
    rc(`ADDR_STATUS, 32'h4);
    wr(`ADDR_PITCTRL, 32'h0);
    repeat (4) @(posedge clk_in);
    check("level", pit_level_out, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    err_count = 0;
    n_tests = 0;
    reset_in = 1'b1;
    ce_in = 1'b1;
    xtal_clk_in = 1'b0;
    ext_clk_in = 1'b0;
    osc_clk_in = 1'b0;
    req = '0;
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    t_regs();
    t_sources();
    t_prescale();
    t_match();
    t_tick();
    summarize();
  end

  // the whole run needs under two thousand cycles; this margin only cuts a hang
  initial begin
    repeat (40000) @(posedge clk_in);
    err_count++;
    summarize();
  end
endmodule
